// file: logic/dps_store.sv
// Drive parameter store: APB register bank with power-class staging,
// RAM-held slots, write protection, threshold monitors and status LEDs.
// Assumes monitor inputs come from logic on clk_sys; a write of the
// control register with bit 0 set stands in for a control power cycle.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [R01] Excess deviation alarm when deviation exceeds threshold, 0.1..100.0 rev, default 15.0.
// [R02] Overload warning once level reaches setting, 10..100 percent, default 50.
// [R03] Station number accepts 1..31 only, resets to 1.
// [R04] Baud code 0,1,2 decodes to 38400, 19200, 9600; default 0.
// [R05] Parameter protect set: all parameter writes refused except the protect flag.
// [R06] Positioning protect set: positioning data edits refused.
// [R07] Keypad shows selected startup item after power-up; default 0.
// [R08] Warning option 1 switches keypad to warning on fan, capacitor, battery.
// [R09] Low battery blinks orange LED at half-second intervals, option ignored.
// [R10] Six RAM parameter slots hold 0 or index 1..299 in three groups.
// [R11] RAM slots accept only always-class parameters; RAM writes unlimited.
// [R12] Power-on loads each RAM-held parameter with its default.
// [R13] Three RAM positioning slots hold 0 or entry 1..15, default 0.
// [R14] Power-on restores RAM-held positioning entries to default.
// [R15] Selector 0: test mode only on request, left at next power cycle.
// [R16] Selector 1: always start in test mode until cleared and cycled.
// [R17] In test mode the status LED blinks rapidly.
// [R18] Host must set encoder select to match motor: 0 wide, 1 narrow.
// [R19] Power-class values take effect only after a power cycle.
// [R20] Out-of-range writes are refused and the old value kept.
module dps_store
  import dps_pkg::*;
#(
  parameter int unsigned SLOW_CYC = dps_pkg::LED_SLOW_CYC,
  parameter int unsigned FAST_CYC = dps_pkg::LED_FAST_CYC
)(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitors
  input wire logic [15:0] position_deviation,
  input wire logic [6:0] overload_level,
  input wire logic fan_life_expired,
  input wire logic cap_life_expired,
  input wire logic battery_low,
  // Indications
  output logic excess_deviation_alarm,
  output logic overload_warning,
  output logic keypad_warning_show,
  output logic led_orange,
  output logic led_status,
  output logic test_mode_active,
  // Active power-class settings
  output dps_pkg::dps_cfg_s active_cfg,
  output logic [15:0] link_baud_bps,
  output logic [4:0] encoder_bits
);
  import dps_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic slot_ok(input logic [8:0] v);
    logic ok;
    ok = 1'b0;
    if (v == 9'h000)
      ok = 1'b1;
    else if (v <= PSLOT_MAX && v != 9'h064 && v != 9'h0c8)
    begin
      if (v > 9'h064 && v < 9'h0c8)
        ok = (v == IDX_DEV) || (v == IDX_OVL) || (v == IDX_PWP) || (v == IDX_DWP); // R11
      else
        ok = 1'b1; // R10
    end
    return ok;
  endfunction

  function automatic logic [15:0] baud_bps(input logic [1:0] c);
    logic [15:0] r;
    r = BPS_0;
    if (c == 2'h1)
      r = BPS_1;
    else if (c == 2'h2)
      r = BPS_2;
    return r; // R04
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [9:0] dev_r;
  logic [6:0] ovl_r;
  logic pwp_r;
  logic dwp_r;
  dps_cfg_s pend_r;
  logic [8:0] pslot_r [N_PSLOT];
  logic [3:0] dslot_r [N_DSLOT];
  logic [31:0] pdat_r [N_PDAT];
  logic [31:0] slow_cnt_r;
  logic [31:0] fast_cnt_r;
  logic acc_ok;
  logic [31:0] rdata;
  logic do_wr;
  logic pcycle;
  logic treq;
  logic [3:0] pd_idx;
  logic in_pdat;

  assign do_wr = ce && psel && penable && pready && pwrite && acc_ok;
  assign pcycle = do_wr && paddr == A_CTRL && pwdata[CTRL_CYCLE_BIT];
  assign treq = do_wr && paddr == A_CTRL && pwdata[CTRL_TEST_BIT];
  assign pd_idx = paddr[5:2];
  assign in_pdat = paddr[11:6] == A_PDAT0[11:6] && paddr[1:0] == 2'h0 && pd_idx != 4'h0;

  // ----------------------------------------------------------------
  // Decode, range check and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    logic prot;
    prot = pwp_r; // R05
    acc_ok = 1'b1;
    rdata = 32'h0000_0000;
    if (in_pdat)
    begin
      rdata = pdat_r[pd_idx];
      acc_ok = !(pwrite && dwp_r); // R06
    end
    else if (paddr >= A_PSLOT0 && paddr < A_DSLOT0 && paddr[1:0] == 2'h0)
    begin
      rdata = {23'h0, pslot_r[3'(paddr[4:2] - 3'h0) ^ 3'h0]};
      acc_ok = !(pwrite && (prot || !slot_ok(pwdata[8:0]) || pwdata[31:9] != 23'h0)); // R20
    end
    else
    begin
      unique case (paddr)
        A_DEV:
        begin
          rdata = {22'h0, dev_r};
          acc_ok = !(pwrite && (prot || pwdata < {22'h0, DEV_MIN} || pwdata > {22'h0, DEV_MAX})); // R20
        end
        A_OVL:
        begin
          rdata = {25'h0, ovl_r};
          acc_ok = !(pwrite && (prot || pwdata < {25'h0, OVL_MIN} || pwdata > {25'h0, OVL_MAX}));
        end
        A_STN:
        begin
          rdata = {27'h0, pend_r.link_station_number};
          acc_ok = !(pwrite && (prot || pwdata < {27'h0, STN_MIN} || pwdata > {27'h0, STN_MAX})); // R03
        end
        A_BAUD:
        begin
          rdata = {30'h0, pend_r.link_baud_code};
          acc_ok = !(pwrite && (prot || pwdata > {30'h0, BAUD_MAX}));
        end
        A_PWP:
        begin
          rdata = {31'h0, pwp_r};
          acc_ok = !(pwrite && pwdata > 32'h0000_0001);
        end
        A_DWP:
        begin
          rdata = {31'h0, dwp_r};
          acc_ok = !(pwrite && (prot || pwdata > 32'h0000_0001));
        end
        A_KEY:
        begin
          rdata = {26'h0, pend_r.keypad_startup_item};
          acc_ok = !(pwrite && (prot || !(pwdata <= {26'h0, KEY_LOW_MAX}
            || (pwdata >= {26'h0, KEY_HIGH_MIN} && pwdata <= {26'h0, KEY_HIGH_MAX}))));
        end
        A_WOPT:
        begin
          rdata = {31'h0, pend_r.warning_display_option};
          acc_ok = !(pwrite && (prot || pwdata > 32'h0000_0001));
        end
        A_DSLOT0, A_DSLOT0 + 12'h004, A_DSLOT0 + 12'h008:
        begin
          rdata = {28'h0, dslot_r[2'(paddr[3:2] - A_DSLOT0[3:2])]};
          acc_ok = !(pwrite && (prot || pwdata > {28'h0, DSLOT_MAX})); // R13
        end
        A_TSEL:
        begin
          rdata = {31'h0, pend_r.test_mode_selector};
          acc_ok = !(pwrite && (prot || pwdata > 32'h0000_0001));
        end
        A_ENC:
        begin
          rdata = {31'h0, pend_r.encoder_width_select};
          acc_ok = !(pwrite && (prot || pwdata > 32'h0000_0001)); // R18
        end
        A_CTRL: rdata = 32'h0000_0000;
        A_STAT:
        begin
          rdata = {22'h0, active_cfg.link_baud_code, active_cfg.link_station_number,
            dwp_r, pwp_r, test_mode_active};
          acc_ok = !pwrite;
        end
        default: acc_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, then pready for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !acc_ok; // R20
      prdata <= (psel && penable && !pready && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Always-class parameters, restored when held in RAM at power-on
  // ----------------------------------------------------------------
  function automatic logic ram_held(input logic [8:0] idx);
    logic h;
    h = 1'b0;
    for (int i = 0; i < N_PSLOT; i++)
      h = h | (pslot_r[i] == idx);
    return h;
  endfunction

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dev_r <= DEV_DEF;
      ovl_r <= OVL_DEF;
      pwp_r <= 1'b0;
      dwp_r <= 1'b0;
    end
    else if (ce)
    begin
      if (pcycle)
      begin
        if (ram_held(IDX_DEV))
          dev_r <= DEV_DEF; // R12
        if (ram_held(IDX_OVL))
          ovl_r <= OVL_DEF;
        if (ram_held(IDX_PWP))
          pwp_r <= 1'b0;
        if (ram_held(IDX_DWP))
          dwp_r <= 1'b0;
      end
      else if (do_wr)
      begin
        if (paddr == A_DEV)
          dev_r <= pwdata[9:0]; // R01
        if (paddr == A_OVL)
          ovl_r <= pwdata[6:0]; // R02
        if (paddr == A_PWP)
          pwp_r <= pwdata[0]; // R05
        if (paddr == A_DWP)
          dwp_r <= pwdata[0]; // R06
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-class settings and slots, applied on a power cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_r <= CFG_DEF;
      active_cfg <= CFG_DEF;
      for (int i = 0; i < N_PSLOT; i++)
        pslot_r[i] <= 9'h000;
      for (int i = 0; i < N_DSLOT; i++)
        dslot_r[i] <= 4'h0;
    end
    else if (ce)
    begin
      if (pcycle)
        active_cfg <= pend_r; // R19
      if (do_wr)
      begin
        unique case (paddr)
          A_STN: pend_r.link_station_number <= pwdata[4:0]; // R03
          A_BAUD: pend_r.link_baud_code <= pwdata[1:0];
          A_KEY: pend_r.keypad_startup_item <= pwdata[5:0]; // R07
          A_WOPT: pend_r.warning_display_option <= pwdata[0];
          A_TSEL: pend_r.test_mode_selector <= pwdata[0];
          A_ENC: pend_r.encoder_width_select <= pwdata[0];
          A_DSLOT0, A_DSLOT0 + 12'h004, A_DSLOT0 + 12'h008:
            dslot_r[2'(paddr[3:2] - A_DSLOT0[3:2])] <= pwdata[3:0]; // R13
          default:
          begin
            if (paddr >= A_PSLOT0 && paddr < A_DSLOT0)
              pslot_r[paddr[4:2]] <= pwdata[8:0]; // R10
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Positioning data table
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < N_PDAT; i++)
        pdat_r[i] <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (pcycle)
      begin
        for (int s = 0; s < N_DSLOT; s++)
          if (dslot_r[s] != 4'h0)
            pdat_r[dslot_r[s]] <= 32'h0000_0000; // R14
      end
      else if (do_wr && in_pdat)
        pdat_r[pd_idx] <= pwdata; // R06
    end
  end

  // ----------------------------------------------------------------
  // Sequence test mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      test_mode_active <= 1'b0;
    else if (ce)
    begin
      if (pcycle)
        test_mode_active <= pend_r.test_mode_selector; // R15 R16
      else if (treq)
        test_mode_active <= 1'b1; // R15
    end
  end

  // ----------------------------------------------------------------
  // Monitors and derived outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      excess_deviation_alarm <= 1'b0;
      overload_warning <= 1'b0;
      keypad_warning_show <= 1'b0;
      link_baud_bps <= BPS_0;
      encoder_bits <= ENC_WIDE;
    end
    else if (ce)
    begin
      excess_deviation_alarm <= position_deviation > {6'h00, dev_r}; // R01
      overload_warning <= overload_level >= ovl_r; // R02
      keypad_warning_show <= active_cfg.warning_display_option
        && (fan_life_expired || cap_life_expired || battery_low); // R08
      link_baud_bps <= baud_bps(active_cfg.link_baud_code); // R04
      encoder_bits <= active_cfg.encoder_width_select ? ENC_NARROW : ENC_WIDE; // R18
    end
  end

  // ----------------------------------------------------------------
  // Status LEDs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      slow_cnt_r <= 32'h0000_0000;
      led_orange <= 1'b0;
    end
    else if (ce)
    begin
      if (!battery_low)
      begin
        slow_cnt_r <= 32'h0000_0000;
        led_orange <= 1'b0;
      end
      else if (slow_cnt_r == SLOW_CYC - 1)
      begin
        slow_cnt_r <= 32'h0000_0000;
        led_orange <= !led_orange; // R09
      end
      else
        slow_cnt_r <= slow_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fast_cnt_r <= 32'h0000_0000;
      led_status <= 1'b0;
    end
    else if (ce)
    begin
      if (!test_mode_active)
      begin
        fast_cnt_r <= 32'h0000_0000;
        led_status <= 1'b0;
      end
      else if (fast_cnt_r == FAST_CYC - 1)
      begin
        fast_cnt_r <= 32'h0000_0000;
        led_status <= !led_status; // R17
      end
      else
        fast_cnt_r <= fast_cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dev_range: assert property (@(posedge clk_sys) disable iff (!rstn) // R01
    dev_r >= DEV_MIN && dev_r <= DEV_MAX) else $error("deviation threshold out of range");
  a_ovl_warn: assert property (@(posedge clk_sys) disable iff (!rstn) // R02
    ce && overload_level >= ovl_r |=> overload_warning) else $error("overload warning missing");
  a_stn_range: assert property (@(posedge clk_sys) disable iff (!rstn) // R03
    pend_r.link_station_number != 5'h00) else $error("station number zero");
  a_pwp_block: assert property (@(posedge clk_sys) disable iff (!rstn) // R05
    pwp_r && ce && psel && penable && pready && pwrite && paddr == A_DEV |=> $stable(dev_r))
    else $error("protected write changed threshold");
  a_dwp_block: assert property (@(posedge clk_sys) disable iff (!rstn) // R06
    dwp_r && in_pdat && psel && penable && pwrite && pready |-> pslverr)
    else $error("protected posdata write accepted");
  a_power_apply: assert property (@(posedge clk_sys) disable iff (!rstn) // R19
    !pcycle |=> $stable(active_cfg)) else $error("active setting changed without cycle");
  a_test_sel: assert property (@(posedge clk_sys) disable iff (!rstn) // R16
    pcycle && pend_r.test_mode_selector |=> test_mode_active) else $error("test mode not entered");
  a_range_err: assert property (@(posedge clk_sys) disable iff (!rstn) // R20
    ce && psel && penable && !pready && pwrite && paddr == A_STN && pwdata > 32'h0000_001f
    |=> pslverr ##1 $stable(pend_r.link_station_number)) else $error("bad station accepted");
  a_warn_opt: assert property (@(posedge clk_sys) disable iff (!rstn) // R08
    ce && !active_cfg.warning_display_option |=> !keypad_warning_show) else $error("warning shown");
  a_led_off: assert property (@(posedge clk_sys) disable iff (!rstn) // R17
    ce && !test_mode_active |=> !led_status) else $error("status LED blinks outside test mode");
  c_power_cycle: cover property (@(posedge clk_sys) disable iff (!rstn) pcycle);
  c_test_req: cover property (@(posedge clk_sys) disable iff (!rstn) treq ##1 test_mode_active);
  c_refused: cover property (@(posedge clk_sys) disable iff (!rstn) pready && pslverr);

endmodule

`default_nettype wire

// file: logic/dps_pkg.sv
// Package for the drive parameter store: offsets, ranges, defaults, timing.
// Assumes a single 250 MHz system clock and an APB register bus.
package dps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LED_SLOW_MS = 500;
  localparam int unsigned LED_FAST_MS = 50;
  localparam int unsigned LED_SLOW_CYC = CLK_HZ / 1000 * LED_SLOW_MS;
  localparam int unsigned LED_FAST_CYC = CLK_HZ / 1000 * LED_FAST_MS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_DEV = 12'h000;
  localparam logic [11:0] A_OVL = 12'h004;
  localparam logic [11:0] A_STN = 12'h008;
  localparam logic [11:0] A_BAUD = 12'h00c;
  localparam logic [11:0] A_PWP = 12'h010;
  localparam logic [11:0] A_DWP = 12'h014;
  localparam logic [11:0] A_KEY = 12'h018;
  localparam logic [11:0] A_WOPT = 12'h01c;
  localparam logic [11:0] A_PSLOT0 = 12'h020;
  localparam logic [11:0] A_DSLOT0 = 12'h038;
  localparam logic [11:0] A_TSEL = 12'h044;
  localparam logic [11:0] A_ENC = 12'h048;
  localparam logic [11:0] A_CTRL = 12'h04c;
  localparam logic [11:0] A_STAT = 12'h050;
  localparam logic [11:0] A_PDAT0 = 12'h100;
  localparam int unsigned N_PSLOT = 6;
  localparam int unsigned N_DSLOT = 3;
  localparam int unsigned N_PDAT = 16;

  // ----------------------------------------------------------------
  // Ranges and defaults (threshold in 0.1 rev units)
  // ----------------------------------------------------------------
  localparam logic [9:0] DEV_MIN = 10'h001;
  localparam logic [9:0] DEV_MAX = 10'h3e8;
  localparam logic [9:0] DEV_DEF = 10'h096;
  localparam logic [6:0] OVL_MIN = 7'h0a;
  localparam logic [6:0] OVL_MAX = 7'h64;
  localparam logic [6:0] OVL_DEF = 7'h32;
  localparam logic [4:0] STN_MIN = 5'h01;
  localparam logic [4:0] STN_MAX = 5'h1f;
  localparam logic [4:0] STN_DEF = 5'h01;
  localparam logic [1:0] BAUD_MAX = 2'h2;
  localparam logic [15:0] BPS_0 = 16'h9600;
  localparam logic [15:0] BPS_1 = 16'h4b00;
  localparam logic [15:0] BPS_2 = 16'h2580;
  localparam logic [5:0] KEY_LOW_MAX = 6'h1b;
  localparam logic [5:0] KEY_HIGH_MIN = 6'h28;
  localparam logic [5:0] KEY_HIGH_MAX = 6'h2d;
  localparam logic [8:0] PSLOT_MAX = 9'h12b;
  localparam logic [8:0] IDX_DEV = 9'h0a9;
  localparam logic [8:0] IDX_OVL = 9'h0aa;
  localparam logic [8:0] IDX_PWP = 9'h0ae;
  localparam logic [8:0] IDX_DWP = 9'h0af;
  localparam logic [3:0] DSLOT_MAX = 4'hf;
  localparam logic [4:0] ENC_WIDE = 5'h14;
  localparam logic [4:0] ENC_NARROW = 5'h12;
  localparam int unsigned CTRL_CYCLE_BIT = 0;
  localparam int unsigned CTRL_TEST_BIT = 1;

  // Power-class settings, held as pending and as active copies
  typedef struct packed {
    logic [4:0] link_station_number;
    logic [1:0] link_baud_code;
    logic [5:0] keypad_startup_item;
    logic warning_display_option;
    logic test_mode_selector;
    logic encoder_width_select;
  } dps_cfg_s;

  localparam dps_cfg_s CFG_DEF = '{STN_DEF, 2'h0, 6'h00, 1'b0, 1'b0, 1'b0};

endpackage

// file: bench/dps_host_model.sv
// APB master model standing in for the keypad or serial host controller.
// Assumes each transfer is started just after a rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module dps_host_model (
  // Clock
  input wire logic clk_sys,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'h0;
  end

  // One transfer, then one idle cycle; released address and data show inverted values
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: bench/drive_parameter_store_control_test.sv
// Self-checking bench for the drive parameter store.
// Assumes dps_store with short blink counts and the APB host model.
`timescale 1ns/100ps
`default_nettype none
module drive_parameter_store_control_test;
  import dps_pkg::*;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  logic clk_sys, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] position_deviation, link_baud_bps;
  logic [6:0] overload_level;
  logic fan_life_expired, cap_life_expired, battery_low;
  logic excess_deviation_alarm, overload_warning, keypad_warning_show, led_orange, led_status, test_mode_active;
  dps_cfg_s active_cfg;
  logic [4:0] encoder_bits;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int t, k, n, s;

  dps_store #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) i_dut (.clk_sys, .rstn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .position_deviation, .overload_level, .fan_life_expired,
    .cap_life_expired, .battery_low, .excess_deviation_alarm, .overload_warning, .keypad_warning_show,
    .led_orange, .led_status, .test_mode_active, .active_cfg, .link_baud_bps, .encoder_bits);
  dps_host_model i_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  // ----------------------------------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic er;
    i_host.xfer(1'b1, a, d, r, er);
    chk($sformatf("wr_err_%h", a), {31'h0, ee}, {31'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    i_host.xfer(1'b0, a, 32'h0, r, er);
    chk($sformatf("rd_err_%h", a), {31'h0, ee}, {31'h0, er});
    chk($sformatf("rd_data_%h", a), e, r);
  endtask

  task automatic blinks(input logic sel, input int e);
    logic l;
    int c;
    c = 0;
    repeat (32)
    begin
      l = sel ? led_status : led_orange;
      @(posedge clk_sys);
      c += ((sel ? led_status : led_orange) !== l);
    end
    chk("blink_count_ok", 32'h1, {31'h0, c >= e - 1 && c <= e + 1});
  endtask

  task automatic pcycle;
    wr(A_CTRL, 32'h1, 1'b0);
    cyc(2);
  endtask

  function automatic logic [15:0] bps(input int c);
    return (c == 0) ? 16'h9600 : (c == 1) ? 16'h4b00 : 16'h2580;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    position_deviation = 16'h0;
    overload_level = 7'h0;
    {fan_life_expired, cap_life_expired, battery_low} = 3'h0;
    s = 1;
    void'($urandom(32'hfa82b428));
    cyc(4);
    rstn <= 1'b1;
    cyc(1);
    chk("baud_bps", 32'h9600, {16'h0, link_baud_bps});
    chk("encoder_bits", 32'h14, {27'h0, encoder_bits});
    for (k = 0; k < 19; k++)
      rd(12'(4 * k), (k == 0) ? 32'h96 : (k == 1) ? 32'h32 : (k == 2) ? 32'h1 : 32'h0, 1'b0);
    wr(A_DEV, 32'h0, 1'b1);
    wr(A_DEV, 32'h3e9, 1'b1);
    wr(A_OVL, 32'h9, 1'b1);
    wr(A_OVL, 32'h65, 1'b1);
    wr(A_STN, 32'h0, 1'b1);
    wr(A_STN, 32'h20, 1'b1);
    wr(A_BAUD, 32'h3, 1'b1);
    wr(A_KEY, 32'h1c, 1'b1);
    wr(A_PSLOT0, 32'h64, 1'b1);
    wr(A_PSLOT0, 32'h96, 1'b1);
    wr(A_PSLOT0, 32'h12c, 1'b1);
    wr(A_PSLOT0, 32'h100, 1'b0);
    wr(A_PSLOT0, 32'h12b, 1'b0);
    wr(A_DSLOT0, 32'h10, 1'b1);
    rd(A_DEV, 32'h96, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    wr(A_STAT, 32'h0, 1'b1);
    for (n = 0; n < 8; n++)
    begin
      t = 1 + $urandom % 1000;
      k = 10 + $urandom % 91;
      wr(A_DEV, 32'(t), 1'b0);
      wr(A_OVL, 32'(k), 1'b0);
      position_deviation <= 16'(t);
      overload_level <= 7'(k - 1);
      cyc(3);
      chk("dev_alarm_at", 32'h0, {31'h0, excess_deviation_alarm});
      chk("ovl_warn_below", 32'h0, {31'h0, overload_warning});
      position_deviation <= 16'(t + 1);
      overload_level <= 7'(k);
      cyc(3);
      chk("dev_alarm_over", 32'h1, {31'h0, excess_deviation_alarm});
      chk("ovl_warn_at", 32'h1, {31'h0, overload_warning});
    end
    for (k = 0; k < 3; k++)
    begin
      t = 1 + $urandom % 31;
      wr(A_STN, 32'(t), 1'b0);
      wr(A_BAUD, 32'(k), 1'b0);
      wr(A_ENC, 32'(k % 2), 1'b0);
      wr(A_KEY, 32'(40 + k), 1'b0);
      cyc(2);
      chk("stn_before", 32'(s), {27'h0, active_cfg.link_station_number});
      pcycle();
      s = t;
      chk("stn_after", 32'(t), {27'h0, active_cfg.link_station_number});
      chk("baud_bps", {16'h0, bps(k)}, {16'h0, link_baud_bps});
      chk("encoder_bits", (k % 2) ? 32'h12 : 32'h14, {27'h0, encoder_bits});
      chk("key_item", 32'(40 + k), {26'h0, active_cfg.keypad_startup_item});
    end
    rd(A_STAT, 32'h200 | 32'(s) << 3, 1'b0);
    wr(A_PWP, 32'h1, 1'b0);
    wr(A_DEV, 32'h5, 1'b1);
    wr(A_PSLOT0, 32'h0, 1'b1);
    wr(A_PWP, 32'h0, 1'b0);
    wr(A_DWP, 32'h1, 1'b0);
    wr(A_PDAT0 + 12'h4, 32'h7, 1'b1);
    wr(A_DWP, 32'h0, 1'b0);
    wr(A_PSLOT0 + 12'h4, 32'ha9, 1'b0);
    wr(A_DSLOT0 + 12'h8, 32'h3, 1'b0);
    wr(A_DEV, 32'h1f4, 1'b0);
    wr(A_OVL, 32'h14, 1'b0);
    wr(A_PDAT0 + 12'hc, 32'h7, 1'b0);
    pcycle();
    rd(A_DEV, 32'h96, 1'b0);
    rd(A_OVL, 32'h14, 1'b0);
    rd(A_PDAT0 + 12'hc, 32'h0, 1'b0);
    wr(A_CTRL, 32'h2, 1'b0);
    cyc(2);
    chk("test_req", 32'h1, {31'h0, test_mode_active});
    blinks(1'b1, 32 / FAST);
    pcycle();
    chk("test_left", 32'h0, {31'h0, test_mode_active});
    chk("led_status_off", 32'h0, {31'h0, led_status});
    wr(A_TSEL, 32'h1, 1'b0);
    pcycle();
    chk("test_start", 32'h1, {31'h0, test_mode_active});
    wr(A_TSEL, 32'h0, 1'b0);
    cyc(2);
    chk("test_kept", 32'h1, {31'h0, test_mode_active});
    pcycle();
    chk("test_cleared", 32'h0, {31'h0, test_mode_active});
    battery_low <= 1'b1;
    cyc(3);
    chk("warn_opt_off", 32'h0, {31'h0, keypad_warning_show});
    blinks(1'b0, 32 / SLOW);
    ce <= 1'b0;
    cyc(1);
    t = led_orange;
    cyc(8);
    chk("ce_freeze", 32'(t), {31'h0, led_orange});
    ce <= 1'b1;
    wr(A_WOPT, 32'h1, 1'b0);
    pcycle();
    for (k = 0; k < 3; k++)
    begin
      {fan_life_expired, cap_life_expired, battery_low} <= 3'(3'h1 << k);
      cyc(3);
      chk("warn_opt_on", 32'h1, {31'h0, keypad_warning_show});
    end
    {fan_life_expired, cap_life_expired, battery_low} <= 3'h0;
    cyc(3);
    chk("warn_clear", 32'h0, {31'h0, keypad_warning_show});
    chk("led_orange_off", 32'h0, {31'h0, led_orange});
    finish_test();
  end
endmodule
`default_nettype wire
